/* rtl/jtx_fifo.sv */
`timescale 1ns/10ps
module jtx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  jtx_strm_if.snk     fill,
  jtx_strm_if.src     drain
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  assign fill.ready  = (cnt_ff != FULL_CNT);
  assign drain.valid = (cnt_ff != '0);
  assign drain.data  = mem[rd_ff];

  always_comb begin
    push = fill.valid && fill.ready;
    pop  = drain.valid && drain.ready;
    nxt_wr  = push ? AW'(wr_ff + 1'b1) : wr_ff;
    nxt_rd  = pop ? AW'(rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage has no reset; only words behind valid are ever read
  always_ff @(posedge clk) begin
    if (push) mem[wr_ff] <= fill.data;
  end
endmodule : jtx_fifo

/* rtl/jtx_pkg.sv */
package jtx_pkg;
  // Lower-rate variant: one parallel clock, two octets per lane per clock
  localparam int LANES        = 2;
  localparam int LANE_W       = 16;
  localparam int OCT_PER_WORD = 2;
  localparam int FLAG_W       = OCT_PER_WORD / 2;
  localparam int F_OCT        = 3;
  localparam int K_FRM        = 16;
  localparam int MF_OCT       = F_OCT * K_FRM;
  localparam int POS_W        = 6;
  localparam int ILAS_MF      = 4;
  localparam int ILAS_W       = 2;
  localparam int FIFO_DEPTH   = 8;
  localparam int TX_W         = LANES * (LANE_W + OCT_PER_WORD);

  localparam logic [7:0] K_CGS = 8'hBC;
  localparam logic [7:0] K_R   = 8'h1C;
  localparam logic [7:0] K_A   = 8'h7C;
  localparam logic [7:0] K_Q   = 8'h9C;
  localparam logic [7:0] K_F   = 8'hFC;

  localparam int CFG_START = 2;
  localparam int CFG_LEN   = 14;
  localparam logic       SCR_EN   = 1'b1;
  // Link identifiers are arbitrary
  localparam logic [7:0] DID      = 8'h5A;
  localparam logic [3:0] BID      = 4'h3;
  localparam logic [7:0] M_CONV   = 8'h02;
  localparam logic [4:0] N_BITS   = 5'h0F;
  localparam logic [4:0] NP_BITS  = 5'h0F;
  localparam logic [4:0] S_SMP    = 5'h00;
  localparam logic [1:0] CS_BITS  = 2'h0;
  localparam logic [4:0] CF_WORDS = 5'h00;
  localparam logic       HD_MODE  = 1'b0;
  localparam logic [2:0] SUBCLASS = 3'h1;
  localparam logic [2:0] JESDV    = 3'h1;

  localparam logic [1:0] CODE_CGS  = 2'h0;
  localparam logic [1:0] CODE_ILAS = 2'h1;
  localparam logic [1:0] CODE_DATA = 2'h2;

  typedef enum logic [1:0] {ST_CGS, ST_ILAS, ST_DATA} jtx_state_e;

  function automatic logic [7:0] cfg_raw(input int lane, input int idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      0:  v = DID;
      1:  v = {4'h0, BID};
      2:  v = 8'(lane);
      3:  v = {SCR_EN, 7'(LANES - 1)};
      4:  v = 8'(F_OCT - 1);
      5:  v = 8'(K_FRM - 1);
      6:  v = M_CONV - 8'h01;
      7:  v = {CS_BITS, 1'b0, N_BITS - 5'h01};
      8:  v = {SUBCLASS, NP_BITS - 5'h01};
      9:  v = {JESDV, S_SMP};
      10: v = {HD_MODE, 2'h0, CF_WORDS};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : cfg_raw

  // Checksum closes the field set, sum of all earlier fields modulo 256
  function automatic logic [7:0] cfg_octet(input int lane, input int idx);
    logic [7:0] sum;
    sum = 8'h00;
    if (idx != CFG_LEN - 1) return cfg_raw(lane, idx);
    for (int i = 0; i < CFG_LEN - 1; i++) sum = sum + cfg_raw(lane, i);
    return sum;
  endfunction : cfg_octet
endpackage : jtx_pkg

/* rtl/jtx_scrambler.sv */
`timescale 1ns/10ps
// Self-synchronous 1 + x^14 + x^15, octets in time order, msb first
module jtx_scrambler (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        step,
  input  wire logic        bypass,
  input  wire logic [15:0] din,
  output logic      [15:0] dout
);
  logic [14:0] lfsr_ff;
  logic [14:0] nxt_lfsr;
  logic [15:0] scr;

  always_comb begin
    logic [14:0] s;
    s = lfsr_ff;
    scr = '0;
    for (int i = 15; i >= 0; i--) begin
      scr[i] = din[i] ^ s[14] ^ s[13];
      s = {s[13:0], scr[i]};
    end
    nxt_lfsr = step ? s : lfsr_ff;
    dout = bypass ? din : scr;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lfsr_ff <= '0;
    else lfsr_ff <= nxt_lfsr;
  end
endmodule : jtx_scrambler

/* rtl/jtx_strm_if.sv */
`timescale 1ns/10ps
interface jtx_strm_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : jtx_strm_if

/* rtl/jtx_tx_core.sv */
`timescale 1ns/10ps
// Functional notes
// - Higher-rate variant adds a half-rate clock; this lower-rate build has none.
// - Multiframe-last flags lead, by one accepted word, the word ending a multiframe.
// - Wider variant: flag bit j marks octets 2j and 2j+1 of next word.
// - Multiframe-first flags lead the word holding a multiframe's first octet.
// - Frame-last flags lead the word holding a frame's last octet.
// - Frame-first flags lead the word holding a frame's first octet.
// - Falling relink request returns the controller to code group sync.
// - Two-bit output reports the transmit controller state.
// - Alignment sequence length input accepted; count fixed at four multiframes.
// - Low converter sync requests sync then alignment sequence.
// - Sixteen bits per lane per clock to the line coder, lanes concatenated.
// - Two control-character flags per lane mark K symbols.
// - Optional scrambler, character insertion, mux of user and init data.
// - Alignment sequence carries all generation-time link parameters.
module jtx_tx_core (
  input  wire logic                                       REF_CLK,
  input  wire logic                                       RSTN,
  input  wire logic [jtx_pkg::LANES*jtx_pkg::LANE_W-1:0]  USR_DATA_IN,
  output logic                                            USR_READY,
  output logic [jtx_pkg::FLAG_W-1:0]                      MULTIFRAME_LAST_LOW_FLAG,
  output logic [jtx_pkg::FLAG_W-1:0]                      MULTIFRAME_LAST_HIGH_FLAG,
  output logic [jtx_pkg::FLAG_W-1:0]                      MULTIFRAME_FIRST_LOW_FLAG,
  output logic [jtx_pkg::FLAG_W-1:0]                      MULTIFRAME_FIRST_HIGH_FLAG,
  output logic [jtx_pkg::FLAG_W-1:0]                      FRAME_LAST_LOW_FLAG,
  output logic [jtx_pkg::FLAG_W-1:0]                      FRAME_LAST_HIGH_FLAG,
  output logic [jtx_pkg::FLAG_W-1:0]                      FRAME_FIRST_LOW_FLAG,
  output logic [jtx_pkg::FLAG_W-1:0]                      FRAME_FIRST_HIGH_FLAG,
  input  wire logic                                       RELINK_REQUEST_LOW,
  output logic [1:0]                                      LINK_STATE,
  input  wire logic [7:0]                                 ALIGN_SEQ_MULTIFRAME_COUNT,
  input  wire logic                                       SYSREF,
  input  wire logic                                       CONV_SYNC_N,
  output logic [jtx_pkg::LANES*16-1:0]                    TX_DATA,
  output logic [jtx_pkg::LANES*2-1:0]                     TX_K,
  output logic                                            TX_VALID,
  input  wire logic                                       TX_READY
);
  localparam int LW = jtx_pkg::LANE_W;
  localparam int NL = jtx_pkg::LANES;
  localparam int OW = jtx_pkg::OCT_PER_WORD;
  localparam int PW = jtx_pkg::POS_W;
  localparam int FW = jtx_pkg::FLAG_W;
  localparam logic [PW-1:0] MF_LAST  = PW'(jtx_pkg::MF_OCT - 1);
  localparam logic [PW-1:0] WRAP_POS = PW'(jtx_pkg::MF_OCT - OW);
  localparam logic [PW-1:0] F_LAST   = PW'(jtx_pkg::F_OCT - 1);
  localparam logic [jtx_pkg::ILAS_W-1:0] ILAS_LAST = jtx_pkg::ILAS_W'(jtx_pkg::ILAS_MF - 1);
  localparam logic [jtx_pkg::ILAS_W-1:0] CFG_MF    = jtx_pkg::ILAS_W'(1);

  logic rst_meta_ff, rst_n_ff;

  // Asynchronous assert, synchronous release
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  jtx_strm_if #(.WIDTH(jtx_pkg::TX_W)) fill_if ();
  jtx_strm_if #(.WIDTH(jtx_pkg::TX_W)) drain_if ();

  jtx_fifo #(.WIDTH(jtx_pkg::TX_W), .DEPTH(jtx_pkg::FIFO_DEPTH)) u_fifo (
    .clk   (REF_CLK),
    .rst_n (rst_n_ff),
    .fill  (fill_if.snk),
    .drain (drain_if.src)
  );

  // Back-pressure from the line side stalls counters, controller and user data
  logic adv;
  assign adv             = fill_if.ready && rst_n_ff;
  assign USR_READY       = adv;
  assign fill_if.valid   = rst_n_ff;
  assign drain_if.ready  = TX_READY;
  assign TX_VALID        = drain_if.valid;
  assign TX_DATA         = drain_if.data[NL*16-1:0];
  assign TX_K            = drain_if.data[jtx_pkg::TX_W-1:NL*16];

  jtx_pkg::jtx_state_e st_ff, nxt_st;
  logic [PW-1:0]       lead_ff, nxt_lead, cur_ff, nxt_cur;
  logic [jtx_pkg::ILAS_W-1:0] ilas_ff, nxt_ilas;
  logic                relink_ff, nxt_relink;
  logic [FW-1:0]       mfl_l_ff, mfl_h_ff, mff_l_ff, mff_h_ff;
  logic [FW-1:0]       fl_l_ff, fl_h_ff, ff_l_ff, ff_h_ff;
  logic [FW-1:0]       nxt_mfl_l, nxt_mfl_h, nxt_mff_l, nxt_mff_h;
  logic [FW-1:0]       nxt_fl_l, nxt_fl_h, nxt_ff_l, nxt_ff_h;
  logic                relink_fall;
  logic [NL*LW-1:0]    scr_word;

  assign relink_fall = relink_ff && !RELINK_REQUEST_LOW;

  generate
    for (genvar l = 0; l < NL; l++) begin : g_scr
      jtx_scrambler u_scr (
        .clk    (REF_CLK),
        .rst_n  (rst_n_ff),
        .step   (adv && st_ff == jtx_pkg::ST_DATA),
        .bypass (!jtx_pkg::SCR_EN),
        .din    (USR_DATA_IN[l*LW +: LW]),
        .dout   (scr_word[l*LW +: LW])
      );
    end
  endgenerate

  // Position counter: lead_ff is the multiframe octet position of the word after the current
  always_comb begin
    logic [PW-1:0] p;
    p = '0;
    nxt_lead = lead_ff;
    nxt_cur  = cur_ff;
    if (adv) begin
      nxt_cur  = lead_ff;
      nxt_lead = (lead_ff == WRAP_POS) ? '0 : PW'(lead_ff + PW'(OW));
    end
    if (SYSREF) nxt_lead = '0;
    for (int j = 0; j < FW; j++) begin
      p = PW'(nxt_lead + PW'(2 * j));
      nxt_mff_h[j] = (p == '0);
      nxt_mfl_h[j] = (p == MF_LAST);
      nxt_ff_h[j]  = ((p % PW'(jtx_pkg::F_OCT)) == '0);
      nxt_fl_h[j]  = ((p % PW'(jtx_pkg::F_OCT)) == F_LAST);
      p = PW'(nxt_lead + PW'(2 * j + 1));
      nxt_mff_l[j] = (p == '0);
      nxt_mfl_l[j] = (p == MF_LAST);
      nxt_ff_l[j]  = ((p % PW'(jtx_pkg::F_OCT)) == '0);
      nxt_fl_l[j]  = ((p % PW'(jtx_pkg::F_OCT)) == F_LAST);
    end
  end

  // Transmit controller
  always_comb begin
    nxt_st     = st_ff;
    nxt_ilas   = ilas_ff;
    nxt_relink = RELINK_REQUEST_LOW;
    if (adv) begin
      case (st_ff)
        jtx_pkg::ST_CGS: begin
          // Alignment starts on a multiframe boundary once sync is released
          if (CONV_SYNC_N && lead_ff == '0) begin
            nxt_st   = jtx_pkg::ST_ILAS;
            nxt_ilas = '0;
          end
        end
        jtx_pkg::ST_ILAS: begin
          if (lead_ff == '0) begin
            nxt_ilas = ilas_ff + 1'b1;
            if (ilas_ff == ILAS_LAST) nxt_st = jtx_pkg::ST_DATA;
          end
        end
        jtx_pkg::ST_DATA: nxt_st = jtx_pkg::ST_DATA;
        default: nxt_st = jtx_pkg::ST_CGS;
      endcase
    end
    if (!CONV_SYNC_N || relink_fall) nxt_st = jtx_pkg::ST_CGS;
  end

  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff     <= jtx_pkg::ST_CGS;
      ilas_ff   <= '0;
      relink_ff <= 1'b1;
      lead_ff   <= '0;
      cur_ff    <= '0;
      mfl_l_ff  <= '0;
      mfl_h_ff  <= '0;
      mff_l_ff  <= '0;
      mff_h_ff  <= '0;
      fl_l_ff   <= '0;
      fl_h_ff   <= '0;
      ff_l_ff   <= '0;
      ff_h_ff   <= '0;
    end else begin
      st_ff     <= nxt_st;
      ilas_ff   <= nxt_ilas;
      relink_ff <= nxt_relink;
      lead_ff   <= nxt_lead;
      cur_ff    <= nxt_cur;
      mfl_l_ff  <= nxt_mfl_l;
      mfl_h_ff  <= nxt_mfl_h;
      mff_l_ff  <= nxt_mff_l;
      mff_h_ff  <= nxt_mff_h;
      fl_l_ff   <= nxt_fl_l;
      fl_h_ff   <= nxt_fl_h;
      ff_l_ff   <= nxt_ff_l;
      ff_h_ff   <= nxt_ff_h;
    end
  end

  assign MULTIFRAME_LAST_LOW_FLAG   = mfl_l_ff;
  assign MULTIFRAME_LAST_HIGH_FLAG  = mfl_h_ff;
  assign MULTIFRAME_FIRST_LOW_FLAG  = mff_l_ff;
  assign MULTIFRAME_FIRST_HIGH_FLAG = mff_h_ff;
  assign FRAME_LAST_LOW_FLAG        = fl_l_ff;
  assign FRAME_LAST_HIGH_FLAG       = fl_h_ff;
  assign FRAME_FIRST_LOW_FLAG       = ff_l_ff;
  assign FRAME_FIRST_HIGH_FLAG      = ff_h_ff;

  always_comb begin
    case (st_ff)
      jtx_pkg::ST_ILAS: LINK_STATE = jtx_pkg::CODE_ILAS;
      jtx_pkg::ST_DATA: LINK_STATE = jtx_pkg::CODE_DATA;
      default:          LINK_STATE = jtx_pkg::CODE_CGS;
    endcase
  end

  // Octet builder; user byte [15:8] is first in time and goes to line byte [7:0]
  logic [NL*16-1:0] oct_word;
  logic [NL*2-1:0]  k_word;
  assign fill_if.data = {k_word, oct_word};

  always_comb begin
    logic [PW-1:0] p;
    logic [7:0]    o;
    logic          k;
    p = '0;
    o = '0;
    k = 1'b0;
    for (int l = 0; l < NL; l++) begin
      for (int t = 0; t < OW; t++) begin
        p = PW'(cur_ff + PW'(t));
        o = jtx_pkg::K_CGS;
        k = 1'b1;
        case (st_ff)
          jtx_pkg::ST_ILAS: begin
            k = 1'b1;
            if (p == '0) o = jtx_pkg::K_R;
            else if (p == MF_LAST) o = jtx_pkg::K_A;
            else if (ilas_ff == CFG_MF && p == PW'(1)) o = jtx_pkg::K_Q;
            else if (ilas_ff == CFG_MF && p >= PW'(jtx_pkg::CFG_START)
                     && p < PW'(jtx_pkg::CFG_START + jtx_pkg::CFG_LEN)) begin
              o = jtx_pkg::cfg_octet(l, int'(p) - jtx_pkg::CFG_START);
              k = 1'b0;
            end else begin
              o = 8'(p);
              k = 1'b0;
            end
          end
          jtx_pkg::ST_DATA: begin
            o = scr_word[l*LW + (OW - 1 - t)*8 +: 8];
            k = 1'b0;
            // Character replacement is only safe with the scrambler on
            if (jtx_pkg::SCR_EN) begin
              if (p == MF_LAST && o == jtx_pkg::K_A) k = 1'b1;
              else if ((p % PW'(jtx_pkg::F_OCT)) == F_LAST
                       && o == jtx_pkg::K_F) k = 1'b1;
            end
          end
          default: begin
            o = jtx_pkg::K_CGS;
            k = 1'b1;
          end
        endcase
        oct_word[l*16 + t*8 +: 8] = o;
        k_word[l*2 + t]           = k;
      end
    end
  end

  // Checks
  logic [7:0] ilas_words;
  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) ilas_words <= '0;
    else if (st_ff != jtx_pkg::ST_ILAS) ilas_words <= '0;
    else if (adv) ilas_words <= ilas_words + 8'h01;
  end

  property p_relink;
    @(posedge REF_CLK) disable iff (!rst_n_ff)
      relink_fall |=> LINK_STATE == jtx_pkg::CODE_CGS;
  endproperty
  a_relink: assert property (p_relink) else $error("relink did not force sync");

  property p_sync_low;
    @(posedge REF_CLK) disable iff (!rst_n_ff)
      !CONV_SYNC_N |=> st_ff == jtx_pkg::ST_CGS ##0 k_word == '1;
  endproperty
  a_sync_low: assert property (p_sync_low) else $error("sync low not honoured");

  property p_sysref_flag;
    @(posedge REF_CLK) disable iff (!rst_n_ff)
      SYSREF |=> MULTIFRAME_FIRST_HIGH_FLAG[0] && !MULTIFRAME_FIRST_LOW_FLAG[0];
  endproperty
  a_sysref_flag: assert property (p_sysref_flag) else $error("sysref realign lost");

  property p_mf_end_frame;
    @(posedge REF_CLK) disable iff (!rst_n_ff)
      MULTIFRAME_LAST_LOW_FLAG[0] |-> FRAME_LAST_LOW_FLAG[0] && !FRAME_LAST_HIGH_FLAG[0];
  endproperty
  a_mf_end_frame: assert property (p_mf_end_frame) else $error("mf end off frame");

  property p_mf_start_frame;
    @(posedge REF_CLK) disable iff (!rst_n_ff)
      MULTIFRAME_FIRST_HIGH_FLAG[0] |-> FRAME_FIRST_HIGH_FLAG[0] ##1
        (FRAME_LAST_HIGH_FLAG[0] || !$past(adv) || $past(SYSREF));
  endproperty
  a_mf_start_frame: assert property (p_mf_start_frame) else $error("frame flags skew");

  property p_ilas_start;
    @(posedge REF_CLK) disable iff (!rst_n_ff)
      $rose(st_ff == jtx_pkg::ST_ILAS) |-> cur_ff == '0 && oct_word[7:0] == jtx_pkg::K_R;
  endproperty
  a_ilas_start: assert property (p_ilas_start) else $error("ilas off boundary");

  property p_ilas_len;
    @(posedge REF_CLK) disable iff (!rst_n_ff)
      (st_ff == jtx_pkg::ST_ILAS ##1 st_ff == jtx_pkg::ST_DATA) |->
        $past(ilas_words) == 8'h5F;
  endproperty
  a_ilas_len: assert property (p_ilas_len) else $error("ilas not four multiframes");

  property p_cfg_q;
    @(posedge REF_CLK) disable iff (!rst_n_ff)
      (st_ff == jtx_pkg::ST_ILAS && ilas_ff == CFG_MF && cur_ff == '0) |->
        oct_word[15:8] == jtx_pkg::K_Q && k_word[1] && oct_word[23:16] == jtx_pkg::K_R;
  endproperty
  a_cfg_q: assert property (p_cfg_q) else $error("config marker missing");
endmodule : jtx_tx_core

/* tb/jtx_line_model.sv */
`timescale 1ns/10ps
// Line side of the coder: prompt, randomly slow, or fully stalled
module jtx_line_model (
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  output logic            ready
);
  initial ready = 1'b0;
  // A real lane may back-pressure on any cycle, so slow mode is random
  always @(posedge clk) begin
    ready <= (mode == 2'h0) || (mode == 2'h1 && $urandom_range(0, 2) != 0);
  end
endmodule : jtx_line_model

/* tb/testbench.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("mismatch %s exp %h got %h", n, e, g); n_fail++; end end
module testbench;
  logic        REF_CLK;
  logic        RSTN;
  logic [31:0] USR_DATA_IN;
  logic        USR_READY;
  logic        MLL, MLH, MFL, MFH, FLL, FLH, FFL, FFH;
  logic        RELINK_REQUEST_LOW;
  logic [1:0]  LINK_STATE;
  logic [7:0]  ALIGN_SEQ_MULTIFRAME_COUNT;
  logic        SYSREF;
  logic        CONV_SYNC_N;
  logic [31:0] TX_DATA;
  logic [3:0]  TX_K;
  logic        TX_VALID;
  logic        TX_READY;
  logic [1:0]  mode;
  int          n_fail;
  int          tests_run;
  logic [36:0] q[$];
  logic [36:0] ew;
  logic [36:0] w;
  logic [8:0]  o;
  logic [1:0]  st;
  logic [1:0]  nst;
  logic        r1, r2, trk, rlq, frc;
  int          p, c, cnt;

  jtx_tx_core i_dut (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .USR_DATA_IN(USR_DATA_IN), .USR_READY(USR_READY),
    .MULTIFRAME_LAST_LOW_FLAG(MLL), .MULTIFRAME_LAST_HIGH_FLAG(MLH),
    .MULTIFRAME_FIRST_LOW_FLAG(MFL), .MULTIFRAME_FIRST_HIGH_FLAG(MFH),
    .FRAME_LAST_LOW_FLAG(FLL), .FRAME_LAST_HIGH_FLAG(FLH),
    .FRAME_FIRST_LOW_FLAG(FFL), .FRAME_FIRST_HIGH_FLAG(FFH),
    .RELINK_REQUEST_LOW(RELINK_REQUEST_LOW), .LINK_STATE(LINK_STATE),
    .ALIGN_SEQ_MULTIFRAME_COUNT(ALIGN_SEQ_MULTIFRAME_COUNT), .SYSREF(SYSREF),
    .CONV_SYNC_N(CONV_SYNC_N), .TX_DATA(TX_DATA), .TX_K(TX_K), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY)
  );
  jtx_line_model i_line (.clk(REF_CLK), .mode(mode), .ready(TX_READY));

  initial REF_CLK = 1'b0;
  always #5 REF_CLK = ~REF_CLK;

  function automatic logic [7:0] cfgv(input int l, input int i);
    logic [7:0] t [13];
    t = '{jtx_pkg::DID, {4'h0, jtx_pkg::BID}, 8'(l), {jtx_pkg::SCR_EN, 7'(jtx_pkg::LANES - 1)},
          8'(jtx_pkg::F_OCT - 1), 8'(jtx_pkg::K_FRM - 1), jtx_pkg::M_CONV - 8'h01,
          {jtx_pkg::CS_BITS, 1'b0, jtx_pkg::N_BITS - 5'h01},
          {jtx_pkg::SUBCLASS, jtx_pkg::NP_BITS - 5'h01}, {jtx_pkg::JESDV, jtx_pkg::S_SMP},
          {jtx_pkg::HD_MODE, 2'h0, jtx_pkg::CF_WORDS}, 8'h00, 8'h00};
    return (i < 13) ? t[i] : t.sum();
  endfunction : cfgv

  function automatic logic [8:0] ilas(input int l, input int m, input int s);
    if (s == 0) return {1'b1, jtx_pkg::K_R};
    if (s == jtx_pkg::MF_OCT - 1) return {1'b1, jtx_pkg::K_A};
    if (m == 1 && s == 1) return {1'b1, jtx_pkg::K_Q};
    if (m == 1 && s >= jtx_pkg::CFG_START && s < jtx_pkg::CFG_START + jtx_pkg::CFG_LEN)
      return {1'b0, cfgv(l, s - jtx_pkg::CFG_START)};
    return {1'b0, 8'(s)};
  endfunction : ilas

  // Flags seen now describe the next accepted word, high octet at p, low at p+1
  function automatic logic [7:0] ef(input int s);
    return {s + 1 == jtx_pkg::MF_OCT - 1, s == jtx_pkg::MF_OCT - 1, (s + 1) % jtx_pkg::MF_OCT == 0,
            s == 0, (s + 1) % 3 == 2, s % 3 == 2, (s + 1) % 3 == 0, s % 3 == 0};
  endfunction : ef

  always @(posedge REF_CLK) begin
    USR_DATA_IN <= $urandom;
    ALIGN_SEQ_MULTIFRAME_COUNT <= 8'($urandom);
    if (RSTN !== 1'b1) begin
      `CHK("reset_outputs", 13'h0, {MLL, MLH, MFL, MFH, FLL, FLH, FFL, FFH, USR_READY, TX_VALID, LINK_STATE, 1'b0})
      q.delete();
      st = 2'h0; trk = 0; r1 = 0; r2 = 0; rlq = 1; p = 0; c = 0;
    end else begin
      `CHK("usr_ready", r2 && q.size() < jtx_pkg::FIFO_DEPTH, USR_READY)
      `CHK("tx_valid", q.size() > 0, TX_VALID)
      `CHK("link_state", st, LINK_STATE)
      if (trk) `CHK("flags", ef(p), {MLL, MLH, MFL, MFH, FLL, FLH, FFL, FFH})
      if (TX_VALID && TX_READY && q.size() > 0) begin
        w = q.pop_front();
        if (w[36]) `CHK("line_word", w[35:0], {TX_K, TX_DATA})
      end
      frc = !CONV_SYNC_N || (rlq && !RELINK_REQUEST_LOW);
      nst = st;
      // The word taken now sits at c; p is the position of the word after it
      if (USR_READY) begin
        ew = '0;
        if (st == 2'h1) begin
          ew[36] = 1'b1;
          for (int l = 0; l < 2; l++)
            for (int t = 0; t < 2; t++) begin
              o = ilas(l, cnt / 24, c + t);
              ew[32 + l * 2 + t] = o[8];
              ew[l * 16 + t * 8 +: 8] = o[7:0];
            end
          cnt++;
          if (cnt == 4 * 24) nst = 2'h2;
        end else if (st == 2'h0) begin
          ew = {1'b1, 4'hF, {4{jtx_pkg::K_CGS}}};
          if (trk && p == 0) begin
            nst = 2'h1;
            cnt = 0;
          end
        end
        q.push_back(ew);
        c = p;
        p = (p + 2) % jtx_pkg::MF_OCT;
      end
      if (frc) nst = 2'h0;
      if (SYSREF && r2) begin
        p = 0;
        trk = 1;
      end
      st = nst; rlq = RELINK_REQUEST_LOW; r2 = r1; r1 = 1;
    end
  end

  task automatic finish_test();
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic wait_state(input logic [1:0] s);
    int i;
    for (i = 0; i < 2000 && LINK_STATE !== s; i++) @(posedge REF_CLK);
    if (i == 2000) begin
      n_fail++;
      finish_test();
    end
  endtask : wait_state

  task automatic pulse_sysref();
    SYSREF <= 1'b1;
    @(posedge REF_CLK);
    SYSREF <= 1'b0;
  endtask : pulse_sysref

  initial begin
    void'($urandom(6455));
    n_fail = 0; tests_run = 0; RSTN = 0; CONV_SYNC_N = 0; RELINK_REQUEST_LOW = 1;
    SYSREF = 0; mode = 2'h0; USR_DATA_IN = '0; ALIGN_SEQ_MULTIFRAME_COUNT = 8'h00;
    repeat (12) @(posedge REF_CLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    pulse_sysref();
    repeat (30) @(posedge REF_CLK);
    mode <= 2'h1;
    CONV_SYNC_N <= 1'b1;
    wait_state(2'h1);
    wait_state(2'h2);
    // Fill the buffer until it refuses, then release the line; pushes keep pace with pops, so the buffer stays near full
    mode <= 2'h2;
    repeat (20) @(posedge REF_CLK);
    mode <= 2'h0;
    repeat (17) @(posedge REF_CLK);
    pulse_sysref();
    repeat (40) @(posedge REF_CLK);
    mode <= 2'h1;
    RELINK_REQUEST_LOW <= 1'b0;
    @(posedge REF_CLK);
    RELINK_REQUEST_LOW <= 1'b1;
    wait_state(2'h0);
    wait_state(2'h2);
    CONV_SYNC_N <= 1'b0;
    wait_state(2'h0);
    repeat (20) @(posedge REF_CLK);
    CONV_SYNC_N <= 1'b1;
    wait_state(2'h2);
    CONV_SYNC_N <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    RSTN <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    pulse_sysref();
    repeat (5) @(posedge REF_CLK);
    CONV_SYNC_N <= 1'b1;
    wait_state(2'h2);
    repeat (20) @(posedge REF_CLK);
    finish_test();
  end
endmodule : testbench
